// *** src/sesr_cfg.svh ***
// Register offsets, field positions, codes and reset values of the status block
// ***************************************************************************
// ***************************************************************************
`ifndef SESR_CFG_SVH
`define SESR_CFG_SVH

// Register word indices on the slave bus
`define SES_A_SESR 4'h0
`define SES_A_DEMASK 4'h1
`define SES_A_ESER 4'h2
`define SES_A_SRER 4'h3
`define SES_A_STB 4'h4
`define SES_A_CMD 4'h5
`define SES_A_QUEUE 4'h6
`define SES_A_STATUS 4'h7

// Event and status byte bit positions
`define SES_B_OPC 0
`define SES_B_DDE 3
`define SES_B_EXE 4
`define SES_B_CME 5
`define SES_B_ESB 5
`define SES_B_MAV 4

// Reset values
`define SES_RST_DEMASK 8'hff
`define SES_RST_MASK 8'h00

// Command codes written to the command register
`define SES_CMD_OPC 2'h1
`define SES_CMD_OPCQ 2'h2

// Message codes
`define SES_C_EMPTY 16'h0000
`define SES_C_PENDING 16'h0001
`define SES_C_ONE 16'h0001
`define SES_C_OVERFLOW 16'h015e
`define SES_C_SEMI 8'h3b

`define SES_QDEPTH 8
`endif

// *** src/ses_pkg.sv ***
// Types shared by the status block
`default_nettype none
package ses_pkg;
   typedef enum logic [2:0] {
      SES_IDLE = 3'h1,
      SES_WAIT = 3'h2,
      SES_DONE = 3'h4
   } ses_opc_t;
endpackage
`default_nettype wire

// *** src/ses_queue.sv ***
// Error and event message queue, flip-flop storage
`default_nettype none
module ses_queue #(
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic push_i,
   input wire logic [15:0] code_i,
   input wire logic pop_i,
   output logic [15:0] head_o,
   output logic empty_o,
   output logic overflow_o
);
   logic [15:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic full;
   logic do_pop;
   logic do_push;

   assign full = (cnt_q == (AW+1)'(DEPTH));
   assign do_pop = pop_i && (cnt_q != '0);
   assign do_push = push_i && (!full || do_pop);
   assign head_o = mem_q[rd_q];
   assign empty_o = (cnt_q == '0);
   assign overflow_o = push_i && !do_push;

   // Storage written when room remains or a pop frees a place in the same cycle
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem_q[wr_q] <= code_i;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= AW'(wr_q + 1'b1);
         end
         if (do_pop) begin
            rd_q <= AW'(rd_q + 1'b1);
         end
         cnt_q <= (AW+1)'(cnt_q + do_push - do_pop);
      end
   end
endmodule
`default_nettype wire

// *** src/ses_top.sv ***
// Status and event reporting block with Avalon-MM register slave
//
// Local design decisions: the Avalon-MM register port and the address map.
`include "sesr_cfg.svh"
`default_nettype none
module ses_top
   import ses_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Command engine side
   input wire logic op_pending_i,
   input wire logic cmd_error_i,
   input wire logic exe_error_i,
   input wire logic dev_error_i,
   input wire logic [15:0] err_code_i,
   input wire logic [7:0] detail_i,
   input wire logic detail_valid_i,
   // Service request, busy answer and detail separator
   output logic srq_o,
   output logic busy_o,
   output logic [7:0] msg_sep_o
);
   // ************************************************************************
   // Register state
   // ************************************************************************
   logic [7:0] sesr_q;
   logic [7:0] demask_q;
   logic [7:0] eser_q;
   logic [7:0] srer_q;
   logic [15:0] outq_q;
   logic outq_vld_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic srq_q;
   logic busy_q;
   logic [7:0] sep_q;
   ses_opc_t opc_q;
   logic opc_query_q;
   logic pend_s1_q;
   logic pend_q;

   logic wr_acc;
   logic rd_take;
   logic [7:0] ev_set;
   logic esb;
   logic [7:0] stb;
   logic q_push;
   logic [15:0] q_code;
   logic q_pop;
   logic [15:0] q_head;
   logic q_empty;
   logic q_ovf;
   logic ovf_pend_q;
   logic opc_fire;

   // Pending flag from the command engine is a level; synchronise it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pend_s1_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         pend_s1_q <= op_pending_i;
         pend_q <= pend_s1_q;
      end
   end

   // One access per two cycles: waitrequest drops in the cycle after request
   assign wr_acc = avs_write_i && !wait_q;
   assign rd_take = avs_read_i && wait_q; // first request edge, once per read
   assign avs_waitrequest_o = wait_q;

   // Waitrequest kept in a flop so the bus output carries no logic
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((avs_read_i || avs_write_i) && wait_q);
      end
   end

   // ************************************************************************
   // Operation-complete sequencer
   // ************************************************************************
   // Armed by the command; fires only once nothing earlier is still in work
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         opc_q <= SES_IDLE;
         opc_query_q <= 1'b0;
      end else begin
         case (opc_q)
            SES_IDLE: begin
               if (wr_acc && avs_address_i == `SES_A_CMD &&
                   avs_writedata_i[1:0] != 2'h0) begin
                  opc_q <= SES_WAIT;
                  opc_query_q <= (avs_writedata_i[1:0] == `SES_CMD_OPCQ);
               end
            end
            SES_WAIT: begin
               if (!pend_q) begin
                  opc_q <= SES_DONE;
               end
            end
            SES_DONE: begin
               opc_q <= SES_IDLE;
            end
            default: begin
               opc_q <= SES_IDLE;
            end
         endcase
      end
   end

   assign opc_fire = (opc_q == SES_DONE);

   // ************************************************************************
   // Event latching
   // ************************************************************************
   // Each event owns one bit, gated by the device mask
   always_comb begin
      ev_set = 8'h00;
      ev_set[`SES_B_OPC] = opc_fire && !opc_query_q;
      ev_set[`SES_B_CME] = cmd_error_i;
      ev_set[`SES_B_EXE] = exe_error_i;
      ev_set[`SES_B_DDE] = dev_error_i && (err_code_i != `SES_C_OVERFLOW);
      ev_set = ev_set & demask_q;
   end

   // Cleared on the edge that captures read data, so no event slips between; set wins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sesr_q <= 8'h00;
      end else if (rd_take && avs_address_i == `SES_A_SESR) begin
         sesr_q <= ev_set;
      end else begin
         sesr_q <= sesr_q | ev_set;
      end
   end

   // Mask registers written by software
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         demask_q <= `SES_RST_DEMASK;
         eser_q <= `SES_RST_MASK;
         srer_q <= `SES_RST_MASK;
      end else if (wr_acc) begin
         if (avs_address_i == `SES_A_DEMASK) begin
            demask_q <= avs_writedata_i[7:0];
         end
         if (avs_address_i == `SES_A_ESER) begin
            eser_q <= avs_writedata_i[7:0];
         end
         if (avs_address_i == `SES_A_SRER) begin
            srer_q <= avs_writedata_i[7:0];
         end
      end
   end

   // ************************************************************************
   // Status byte and service request
   // ************************************************************************
   assign esb = |(sesr_q & eser_q);
   always_comb begin
      stb = 8'h00;
      stb[`SES_B_ESB] = esb;
      stb[`SES_B_MAV] = outq_vld_q;
   end

   // Request raised while any enabled status byte bit stands
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         srq_q <= 1'b0;
      end else begin
         srq_q <= |(stb & srer_q);
      end
   end

   // Busy answer mirrors extended processing in work
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= pend_q || (opc_q == SES_WAIT);
      end
   end

   // ************************************************************************
   // Output queue (query answers)
   // ************************************************************************
   // The value 1 appears only after the wait ends; reads before that see none
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         outq_q <= 16'h0000;
         outq_vld_q <= 1'b0;
      end else if (opc_fire && opc_query_q) begin
         outq_q <= `SES_C_ONE;
         outq_vld_q <= 1'b1;
      end else if (rd_take && avs_address_i == `SES_A_QUEUE && outq_vld_q) begin
         outq_vld_q <= 1'b0;
      end
   end

   // ************************************************************************
   // Message queue
   // ************************************************************************
   // Codes come straight from the engine: 100s, 200s, 300s families
   assign q_push = cmd_error_i || exe_error_i || dev_error_i;
   assign q_code = err_code_i;
   assign q_pop = rd_take && avs_address_i == `SES_A_STATUS;

   ses_queue #(
      .DEPTH(`SES_QDEPTH),
      .AW(3)
   ) u_queue (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .push_i(q_push),
      .code_i(q_code),
      .pop_i(q_pop),
      .head_o(q_head),
      .empty_o(q_empty),
      .overflow_o(q_ovf)
   );

   // Overflow remembered and reported once the queue drains; no event bit
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ovf_pend_q <= 1'b0;
      end else if (q_ovf) begin
         ovf_pend_q <= 1'b1;
      end else if (q_pop && q_empty) begin
         ovf_pend_q <= 1'b0;
      end
   end

   // Detail text separator emitted ahead of each detail byte
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sep_q <= 8'h00;
      end else if (detail_valid_i) begin
         sep_q <= `SES_C_SEMI;
      end else begin
         sep_q <= detail_i;
      end
   end

   // ************************************************************************
   // Read data
   // ************************************************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_take) begin
         case (avs_address_i)
            `SES_A_SESR: rdata_q <= {24'h0, sesr_q};
            `SES_A_DEMASK: rdata_q <= {24'h0, demask_q};
            `SES_A_ESER: rdata_q <= {24'h0, eser_q};
            `SES_A_SRER: rdata_q <= {24'h0, srer_q};
            `SES_A_STB: rdata_q <= {24'h0, stb | {1'b0, srq_q, 6'h0}};
            `SES_A_QUEUE: rdata_q <= {15'h0, outq_vld_q, outq_q};
            `SES_A_STATUS: begin
               if (!q_empty) begin
                  rdata_q <= {16'h0, q_head};
               end else if (ovf_pend_q) begin
                  rdata_q <= {16'h0, `SES_C_OVERFLOW};
               end else if (sesr_q != 8'h00) begin
                  rdata_q <= {16'h0, `SES_C_PENDING};
               end else begin
                  rdata_q <= {16'h0, `SES_C_EMPTY};
               end
            end
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_readdata_o = rdata_q;
   assign srq_o = srq_q;
   assign busy_o = busy_q;
   assign msg_sep_o = sep_q;

   // ************************************************************************
   // Checks
   // ************************************************************************
   property p_opc_after_idle;
      @(posedge clk_i) disable iff (srst_i)
      (opc_q == SES_WAIT && !pend_q) |=> opc_fire;
   endproperty
   a_opc_after_idle: assert property (p_opc_after_idle)
      else $error("completion did not follow end of pending work");

   property p_opc_bit;
      @(posedge clk_i) disable iff (srst_i)
      (opc_fire && !opc_query_q && demask_q[`SES_B_OPC]) |=> sesr_q[`SES_B_OPC];
   endproperty
   a_opc_bit: assert property (p_opc_bit)
      else $error("operation complete bit not set");

   property p_srq;
      @(posedge clk_i) disable iff (srst_i)
      (esb && srer_q[`SES_B_ESB]) |=> srq_q;
   endproperty
   a_srq: assert property (p_srq)
      else $error("service request missing");

   property p_cme;
      @(posedge clk_i) disable iff (srst_i)
      (cmd_error_i && demask_q[`SES_B_CME]) |=> sesr_q[`SES_B_CME];
   endproperty
   a_cme: assert property (p_cme)
      else $error("command error bit not set");

   property p_exe;
      @(posedge clk_i) disable iff (srst_i)
      (exe_error_i && demask_q[`SES_B_EXE]) |=> sesr_q[`SES_B_EXE];
   endproperty
   a_exe: assert property (p_exe)
      else $error("execution error bit not set");

   property p_gate;
      @(posedge clk_i) disable iff (srst_i)
      (!demask_q[`SES_B_CME] && !sesr_q[`SES_B_CME]) |=> !sesr_q[`SES_B_CME];
   endproperty
   a_gate: assert property (p_gate)
      else $error("masked event latched");

   property p_query;
      @(posedge clk_i) disable iff (srst_i)
      (opc_fire && opc_query_q) |=> (outq_vld_q && outq_q == `SES_C_ONE);
   endproperty
   a_query: assert property (p_query)
      else $error("completion query answer missing");

   property p_busy;
      @(posedge clk_i) disable iff (srst_i)
      (opc_q == SES_WAIT) |=> busy_q;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy not reported while waiting");
endmodule
`default_nettype wire

// *** tb/ses_engine.sv ***
// Command engine model: fault pulses with their message codes
`default_nettype none
module ses_engine (
   input wire logic clk_i,
   output logic cmd_error_o,
   output logic exe_error_o,
   output logic dev_error_o,
   output logic [15:0] err_code_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Idle levels at time zero
   // ************************************************************
   initial begin
      cmd_error_o = 1'b0;
      exe_error_o = 1'b0;
      dev_error_o = 1'b0;
      err_code_o = 16'h0000;
   end

   // One-cycle fault pulse with its code: 0 syntax, 1 execution, 2 device
   task automatic raise(input int kind, input logic [15:0] code);
      @(posedge clk_i);
      cmd_error_o <= (kind == 0);
      exe_error_o <= (kind == 1);
      dev_error_o <= (kind == 2);
      err_code_o <= code;
      @(posedge clk_i);
      cmd_error_o <= 1'b0;
      exe_error_o <= 1'b0;
      dev_error_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** tb/status_event_sync_reporting_bench.sv ***
// Self-checking bench of the status and event reporting block
`include "sesr_cfg.svh"
`default_nettype none
module status_event_sync_reporting_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] A_QRY = 4'h6;
   localparam logic [3:0] A_POP = 4'h7;
   localparam int LIMIT = 20000;
   // Syntax fault codes 100 to 184 in hex
   localparam logic [15:0] CODES [23] = '{16'h0064, 16'h0067, 16'h006a, 16'h006f,
      16'h0078, 16'h0079, 16'h007b, 16'h007c, 16'h008c, 16'h008d, 16'h0090, 16'h0096,
      16'h0097, 16'h0098, 16'h00a0, 16'h00a1, 16'h00a8, 16'h00aa, 16'h00ab, 16'h00b2,
      16'h00b4, 16'h00b5, 16'h00b8};
   logic clk_i;
   logic srst_i;
   logic [3:0] avs_address_i;
   logic avs_read_i;
   logic avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic op_pending;
   logic cmd_error;
   logic exe_error;
   logic dev_error;
   logic [15:0] err_code;
   logic [7:0] detail;
   logic detail_valid;
   logic srq_o;
   logic busy_o;
   logic [7:0] msg_sep_o;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   ses_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .op_pending_i(op_pending), .cmd_error_i(cmd_error), .exe_error_i(exe_error),
      .dev_error_i(dev_error), .err_code_i(err_code), .detail_i(detail),
      .detail_valid_i(detail_valid), .srq_o(srq_o), .busy_o(busy_o), .msg_sep_o(msg_sep_o));

   ses_engine i_eng (.clk_i(clk_i), .cmd_error_o(cmd_error), .exe_error_o(exe_error),
      .dev_error_o(dev_error), .err_code_o(err_code));

   // ************************************************************
   // Clock, timeout and verdict
   // ************************************************************
   always #10 clk_i = ~clk_i;

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Avalon cycle; request held until the rising edge that samples waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] d);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= wd;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         @(posedge clk_i);
      end
      d = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, a, wd, d);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(nm, exp, d);
   endtask

   // Engine work in flight; a level that the block synchronises
   task automatic set_pending(input logic v);
      @(posedge clk_i);
      op_pending <= v;
   endtask

   // Detail byte; returns on the edge that samples the strobe
   task automatic send_detail(input logic [7:0] b);
      @(posedge clk_i);
      detail <= b;
      detail_valid <= 1'b1;
      @(posedge clk_i);
      detail_valid <= 1'b0;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      int n;
      logic [31:0] d;
      clk_i = 1'b0;
      srst_i = 1'b1;
      avs_address_i = 4'h0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      op_pending = 1'b0;
      detail = 8'h00;
      detail_valid = 1'b0;
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      // Reset values and an unmapped index
      rd(`SES_A_DEMASK, 32'h0000_00ff, "demask");
      rd(`SES_A_ESER, 32'h0, "eser");
      rd(`SES_A_SRER, 32'h0, "srer");
      rd(4'h8, 32'h0, "unmapped");
      rd(A_POP, 32'h0, "empty pop");
      // Completion via serial poll, service request masked off
      wr(`SES_A_DEMASK, 32'h1);
      wr(`SES_A_ESER, 32'h1);
      set_pending(1'b1);
      repeat (6) @(posedge clk_i);
      chk("busy", 32'h1, {31'h0, busy_o});
      wr(`SES_A_CMD, {30'h0, `SES_CMD_OPC});
      repeat (6) @(posedge clk_i);
      rd(`SES_A_STB, 32'h0, "stb early");
      set_pending(1'b0);
      repeat (6) @(posedge clk_i);
      chk("busy off", 32'h0, {31'h0, busy_o});
      rd(`SES_A_STB, 32'h20, "stb summary");
      chk("srq masked", 32'h0, {31'h0, srq_o});
      rd(`SES_A_SESR, 32'h1, "opc bit");
      rd(`SES_A_SESR, 32'h0, "clear on read");
      // Service request with mask 32
      wr(`SES_A_SRER, 32'h20);
      set_pending(1'b1);
      wr(`SES_A_CMD, {30'h0, `SES_CMD_OPC});
      set_pending(1'b0);
      n = 0;
      while (srq_o !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      chk("srq", 32'h1, {31'h0, srq_o});
      rd(`SES_A_STB, 32'h60, "stb srq");
      rd(`SES_A_SESR, 32'h1, "opc bit again");
      repeat (4) @(posedge clk_i);
      chk("srq cleared", 32'h0, {31'h0, srq_o});
      // Completion query; the pending work outlasts the first wait below, so the early read sees no answer
      wr(`SES_A_SRER, 32'h0);
      set_pending(1'b1);
      wr(`SES_A_CMD, {30'h0, `SES_CMD_OPCQ});
      repeat (6) @(posedge clk_i);
      rd(A_QRY, 32'h0, "query early");
      set_pending(1'b0);
      repeat (8) @(posedge clk_i);
      rd(A_QRY, 32'h0001_0001, "query answer");
      bus(1'b0, `SES_A_SESR, 32'h0, d);
      // Every syntax code listed goes through the queue
      wr(`SES_A_DEMASK, 32'hff);
      for (int i = 0; i < 23; i++) begin
         i_eng.raise(0, CODES[i]);
         repeat (3) @(posedge clk_i);
         d = {16'h0, CODES[i]};
         rd(A_POP, d, "syntax code");
      end
      rd(A_POP, 32'h1, "events pending");
      rd(`SES_A_SESR, 32'h20, "syntax bit");
      rd(A_POP, 32'h0, "queue empty");
      i_eng.raise(1, 16'h00c8);
      repeat (3) @(posedge clk_i);
      rd(A_POP, 32'h00c8, "exec code");
      rd(`SES_A_SESR, 32'h10, "exec bit");
      i_eng.raise(2, 16'h012c);
      repeat (3) @(posedge clk_i);
      rd(A_POP, 32'h012c, "device code");
      rd(`SES_A_SESR, 32'h08, "device bit");
      // Nine device faults into eight places
      for (int i = 0; i < 9; i++) begin
         i_eng.raise(2, 16'h0136 + 16'(i));
      end
      repeat (3) @(posedge clk_i);
      rd(`SES_A_SESR, 32'h08, "device bit full");
      for (int i = 0; i < 8; i++) begin
         rd(A_POP, 32'h0136 + 32'(i), "queued code");
      end
      rd(A_POP, {16'h0, `SES_C_OVERFLOW}, "overflow code");
      // Overflow code reported by the engine queues but sets no device bit
      i_eng.raise(2, `SES_C_OVERFLOW);
      repeat (3) @(posedge clk_i);
      rd(`SES_A_SESR, 32'h0, "overflow no bit");
      rd(A_POP, {16'h0, `SES_C_OVERFLOW}, "overflow queued");
      // Device mask bit 5 off blocks the syntax bit
      wr(`SES_A_DEMASK, 32'hdf);
      i_eng.raise(0, 16'h0066);
      repeat (3) @(posedge clk_i);
      rd(`SES_A_SESR, 32'h0, "masked syntax");
      // Detail text separator
      send_detail(8'h41);
      @(negedge clk_i);
      chk("separator", {24'h0, `SES_C_SEMI}, {24'h0, msg_sep_o});
      @(negedge clk_i);
      chk("detail byte", 32'h41, {24'h0, msg_sep_o});
      test_done();
   end
endmodule
`default_nettype wire
